/* File: pkg/core_pkg.sv */
// shared constants and types of the quad phase fetch/execute core
package core_pkg;
   // ---------------------------------------------------------------
   // widths and program space
   // ---------------------------------------------------------------
   localparam int         PROG_AW       = 11;
   localparam int         INSN_W        = 12;
   localparam int         DATA_W        = 8;
   localparam logic [10:0] RESET_VECTOR  = 11'h000;
   localparam logic [10:0] FLASH_DATA_LO = 11'h600;
   localparam logic [10:0] FLASH_DATA_HI = 11'h63F;
   // ---------------------------------------------------------------
   // data space map and reset values
   // ---------------------------------------------------------------
   localparam logic [7:0] ADDR_INDIRECT = 8'h00;
   localparam logic [7:0] ADDR_PCL      = 8'h02;
   localparam logic [7:0] ADDR_STATUS   = 8'h03;
   localparam logic [7:0] ADDR_POINTER  = 8'h04;
   localparam logic [4:0] UNBANKED_TOP  = 5'h07;
   localparam logic [7:0] STATUS_RESET  = 8'h18;
   localparam logic [7:0] POINTER_RESET = 8'h00;
   localparam logic [7:0] W_RESET       = 8'h00;
   localparam int         ST_C          = 0;
   localparam int         ST_HALF       = 1;
   localparam int         ST_Z          = 2;
   localparam int         ST_PAGE_LO    = 5;
   localparam int         ST_PA1        = 6;
   // ---------------------------------------------------------------
   // instruction classes and sub codes
   // ---------------------------------------------------------------
   localparam logic [1:0] CLS_FILE  = 2'h0;
   localparam logic [1:0] CLS_BIT   = 2'h1;
   localparam logic [1:0] CLS_JUMP  = 2'h2;
   localparam logic [1:0] CLS_LIT   = 2'h3;
   localparam logic [1:0] LIT_MOV   = 2'h0;
   localparam logic [1:0] LIT_AND   = 2'h1;
   localparam logic [1:0] LIT_OR    = 2'h2;
   localparam logic [1:0] LIT_XOR   = 2'h3;
   typedef enum logic [3:0] {PH_ONE = 4'b0001, PH_TWO = 4'b0010,
                             PH_THREE = 4'b0100, PH_FOUR = 4'b1000} phase_t;
   typedef enum logic [3:0] {ALU_ADD = 4'h0, ALU_SUB = 4'h1, ALU_AND = 4'h2,
                             ALU_OR = 4'h3, ALU_XOR = 4'h4, ALU_MOVF = 4'h5,
                             ALU_COM = 4'h6, ALU_INC = 4'h7, ALU_DEC = 4'h8,
                             ALU_RLF = 4'h9, ALU_RRF = 4'hA, ALU_SWAP = 4'hB,
                             ALU_CLR = 4'hC, ALU_PASSW = 4'hD, ALU_MOVK = 4'hE,
                             ALU_NOP = 4'hF} alu_op_t;
endpackage : core_pkg

/* File: pkg/alu_if.sv */
// carrier between the sequencing core and its arithmetic unit
interface alu_if;
   import core_pkg::*;
   alu_op_t    op;
   logic [7:0] a;
   logic [7:0] w;
   logic       cin;
   logic [7:0] res;
   logic [2:0] flags;
   logic [2:0] mask;
   modport core (output op, a, w, cin, input res, flags, mask);
   modport alu  (input op, a, w, cin, output res, flags, mask);
endinterface : alu_if

/* File: verilog/alu_unit.sv */
// eight bit arithmetic unit with carry, half carry and zero flags
module alu_unit import core_pkg::*; (
   alu_if.alu bus
);
   logic [8:0] sum;
   logic [4:0] nib;
   always_comb begin
      sum = 9'h000;
      nib = 5'h00;
      bus.res = bus.a;
      bus.flags = 3'h0;
      bus.mask = 3'h1 << ST_Z;
      unique case (bus.op)
         ALU_ADD: begin
            sum = {1'b0, bus.a} + {1'b0, bus.w};
            nib = {1'b0, bus.a[3:0]} + {1'b0, bus.w[3:0]};
            bus.res = sum[7:0];
            bus.mask = 3'h7;
         end
         ALU_SUB: begin
            // carry out of a + ~w + 1 is the inverted borrow
            sum = {1'b0, bus.a} + {1'b0, ~bus.w} + 9'h001;
            nib = {1'b0, bus.a[3:0]} + {1'b0, ~bus.w[3:0]} + 5'h01;
            bus.res = sum[7:0];
            bus.mask = 3'h7;
         end
         ALU_AND:  bus.res = bus.a & bus.w;
         ALU_OR:   bus.res = bus.a | bus.w;
         ALU_XOR:  bus.res = bus.a ^ bus.w;
         ALU_MOVF: bus.res = bus.a;
         ALU_COM:  bus.res = ~bus.a;
         ALU_INC:  bus.res = bus.a + 8'h01;
         ALU_DEC:  bus.res = bus.a - 8'h01;
         ALU_RLF: begin
            bus.res = {bus.a[6:0], bus.cin};
            sum = {bus.a[7], 8'h00};
            bus.mask = 3'h1 << ST_C;
         end
         ALU_RRF: begin
            bus.res = {bus.cin, bus.a[7:1]};
            sum = {bus.a[0], 8'h00};
            bus.mask = 3'h1 << ST_C;
         end
         ALU_SWAP: begin
            bus.res = {bus.a[3:0], bus.a[7:4]};
            bus.mask = 3'h0;
         end
         ALU_CLR:  bus.res = 8'h00;
         ALU_PASSW: begin
            bus.res = bus.w;
            bus.mask = 3'h0;
         end
         ALU_MOVK, ALU_NOP: begin
            bus.res = bus.a;
            bus.mask = 3'h0;
         end
      endcase
      bus.flags[ST_C]  = sum[8];
      bus.flags[ST_HALF] = nib[4];
      bus.flags[ST_Z]  = (bus.res == 8'h00);
   end
endmodule : alu_unit

/* File: verilog/quad_phase_fetch_execute_core.sv */
// two stage fetch/execute sequencer clocked by four rotating phases
// Contract
// - divide the clock by four into four non-overlapping phases per instruction cycle
// - advance the program counter in phase one, latch the program word in phase four
// - hold the fetched word from phase one, decode and execute in phases one to four
// - read the data operand in phase two, write the destination in phase four
// - fetch of the next word overlaps execution of the current one
// - a program counter change takes two cycles; the prefetched word is discarded
// - twelve bit words arrive on their own program bus, apart from the data bus
// - eight bit unit with add, subtract, shift and logic, two's complement
// - two-operand ops use the accumulator and a file register or a constant
// - the working accumulator feeds the unit and has no data address
// - the unit updates carry, half carry and zero in the status register
// - on subtract carry and half carry mean no borrow
// - special registers, program counter included, reachable directly and indirectly
// - the self-writable data area sits at program addresses 600h to 63Fh; the core has no program write path and only keeps fetches below PROG_WORDS
// - program pages are chosen by page bits of the status register
// - data banks are chosen through the indirect pointer
// - start fetching at 0000h; addresses past the code space wrap inside it
// - a status destination does not overwrite flags the instruction itself sets
module quad_phase_fetch_execute_core import core_pkg::*; #(
   parameter logic [10:0] PROG_WORDS = FLASH_DATA_LO
) (
   input  wire logic        i_core_clk,
   input  wire logic        i_rst,
   input  wire logic [11:0] i_prog_data,
   input  wire logic [7:0]  i_dmem_rdata,
   output logic [10:0]      o_prog_addr,
   output logic             o_phase_one,
   output logic             o_phase_two,
   output logic             o_phase_three,
   output logic             o_phase_four,
   output logic [7:0]       o_dmem_addr,
   output logic             o_dmem_rd,
   output logic             o_dmem_wr,
   output logic [7:0]       o_dmem_wdata,
   output logic [7:0]       o_working,
   output logic [7:0]       o_status,
   output logic [7:0]       o_indirect_pointer,
   output logic             o_exec_valid
);
   // ---------------------------------------------------------------
   // declarations
   // ---------------------------------------------------------------
   phase_t      phase;
   logic [10:0] fetch_pc;
   logic [11:0] instruction_latch;
   logic [10:0] exec_addr;
   logic [10:0] next_addr;
   logic [10:0] fetch_wrap;
   logic [10:0] fetch_inc;
   logic [10:0] target;
   logic [7:0]  operand;
   logic [7:0]  res_q;
   logic [2:0]  flags_q;
   logic [2:0]  mask_q;
   logic [7:0]  eff_addr;
   logic [7:0]  int_rd;
   logic [7:0]  bit_val;
   logic [7:0]  next_status;
   logic [4:0]  f;
   logic [1:0]  cls;
   logic [1:0]  sub;
   logic        is_file;
   logic        is_bit;
   logic        is_goto;
   logic        is_lit;
   logic        internal_sel;
   logic        write_file;
   logic        write_w;
   logic        skip;
   logic        flush_now;
   logic        seen_fetch;
   alu_op_t     op;
   alu_if       alu_bus ();

   function automatic logic [10:0] prog_wrap(input logic [10:0] a);
      // code space ends where the flash data area begins
      return (a >= PROG_WORDS) ? a - PROG_WORDS : a;
   endfunction : prog_wrap

   // ---------------------------------------------------------------
   // phase generator
   // ---------------------------------------------------------------
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         phase <= PH_ONE;
      end else begin
         unique case (phase)
            PH_ONE:   phase <= PH_TWO;
            PH_TWO:   phase <= PH_THREE;
            PH_THREE: phase <= PH_FOUR;
            PH_FOUR:  phase <= PH_ONE;
         endcase
      end
   end
   assign o_phase_one   = phase[0];
   assign o_phase_two   = phase[1];
   assign o_phase_three = phase[2];
   assign o_phase_four  = phase[3];

   // ---------------------------------------------------------------
   // decode of the latched word
   // ---------------------------------------------------------------
   assign cls     = instruction_latch[11:10];
   assign sub     = instruction_latch[9:8];
   assign f       = instruction_latch[4:0];
   assign is_file = (cls == CLS_FILE);
   assign is_bit  = (cls == CLS_BIT);
   assign is_goto = (cls == CLS_JUMP) && !instruction_latch[9];
   assign is_lit  = (cls == CLS_LIT);

   always_comb begin
      if (f == 5'h00) begin
         eff_addr = o_indirect_pointer;
      end else if (f <= UNBANKED_TOP) begin
         eff_addr = {3'h0, f};
      end else begin
         eff_addr = {o_indirect_pointer[7:5], f};
      end
   end

   assign next_addr = exec_addr + 11'h001;
   // the accumulator has no entry here, so no address ever reaches it
   always_comb begin
      unique case (eff_addr)
         ADDR_PCL:    int_rd = next_addr[7:0];
         ADDR_STATUS: int_rd = o_status;
         ADDR_POINTER: int_rd = o_indirect_pointer;
         default:     int_rd = 8'h00;
      endcase
   end
   assign internal_sel = (eff_addr == ADDR_INDIRECT) || (eff_addr == ADDR_PCL) ||
                         (eff_addr == ADDR_STATUS) || (eff_addr == ADDR_POINTER);

   always_comb begin
      op = ALU_NOP;
      if (is_file) begin
         op = alu_op_t'(instruction_latch[9:6]);
      end else if (is_bit) begin
         op = ALU_MOVK;
      end else if (is_lit) begin
         unique case (sub)
            LIT_MOV: op = ALU_MOVK;
            LIT_AND: op = ALU_AND;
            LIT_OR:  op = ALU_OR;
            LIT_XOR: op = ALU_XOR;
         endcase
      end
   end

   assign bit_val = sub[0] ? operand | (8'h01 << instruction_latch[7:5])
                           : operand & ~(8'h01 << instruction_latch[7:5]);
   assign skip = is_bit && sub[1] && (operand[instruction_latch[7:5]] == sub[0]);
   assign write_file = (is_file && (instruction_latch[5] || op == ALU_PASSW)) ||
                       (is_bit && !sub[1]);
   assign write_w = (is_file && !instruction_latch[5] && op != ALU_PASSW) || is_lit;

   assign alu_bus.op  = op;
   assign alu_bus.a   = is_lit ? instruction_latch[7:0] : (is_bit ? bit_val : operand);
   assign alu_bus.w   = o_working;
   assign alu_bus.cin = o_status[ST_C];

   alu_unit u_alu (
      .bus (alu_bus)
   );

   // ---------------------------------------------------------------
   // fetch stage and flush
   // ---------------------------------------------------------------
   assign fetch_wrap = prog_wrap(fetch_pc);
   assign fetch_inc  = prog_wrap(fetch_wrap + 11'h001);
   // page bits above the literal or the low byte
   assign target = is_goto ? {o_status[ST_PA1], o_status[ST_PAGE_LO], instruction_latch[8:0]}
                           : {o_status[ST_PA1], o_status[ST_PAGE_LO], 1'b0, res_q};
   assign flush_now = o_exec_valid &&
                      (is_goto || skip || (write_file && eff_addr == ADDR_PCL));

   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         fetch_pc          <= RESET_VECTOR;
         o_prog_addr       <= RESET_VECTOR;
         instruction_latch <= 12'h000;
         exec_addr         <= RESET_VECTOR;
         o_exec_valid      <= 1'b0;
      end else if (phase == PH_ONE) begin
         o_prog_addr <= fetch_wrap;
         fetch_pc    <= fetch_inc;
      end else if (phase == PH_FOUR) begin
         instruction_latch <= i_prog_data;
         exec_addr         <= o_prog_addr;
         o_exec_valid      <= !flush_now;
         if (flush_now && !skip) begin
            fetch_pc <= prog_wrap(target);
         end
      end
   end

   // ---------------------------------------------------------------
   // data bus and execute stage
   // ---------------------------------------------------------------
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         o_dmem_addr  <= 8'h00;
         o_dmem_rd    <= 1'b0;
         o_dmem_wr    <= 1'b0;
         o_dmem_wdata <= 8'h00;
      end else begin
         unique case (phase)
            PH_ONE: begin
               o_dmem_addr <= eff_addr;
               o_dmem_rd   <= o_exec_valid && (is_file || is_bit) && !internal_sel;
            end
            PH_TWO: o_dmem_rd <= 1'b0;
            PH_THREE: begin
               o_dmem_wdata <= alu_bus.res;
               o_dmem_wr    <= o_exec_valid && write_file && !internal_sel;
            end
            PH_FOUR: o_dmem_wr <= 1'b0;
         endcase
      end
   end

   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         operand <= 8'h00;
         res_q   <= 8'h00;
         flags_q <= 3'h0;
         mask_q  <= 3'h0;
      end else if (phase == PH_TWO) begin
         operand <= internal_sel ? int_rd : i_dmem_rdata;
      end else if (phase == PH_THREE) begin
         res_q   <= alu_bus.res;
         flags_q <= alu_bus.flags;
         mask_q  <= alu_bus.mask;
      end
   end

   always_comb begin
      next_status = o_status;
      if (write_file && eff_addr == ADDR_STATUS) begin
         next_status[7:5] = res_q[7:5];
         // flags the instruction sets are not overwritten by its own result
         if (mask_q == 3'h0) begin
            next_status[2:0] = res_q[2:0];
         end
      end
      next_status[2:0] = (next_status[2:0] & ~mask_q) | (flags_q & mask_q);
   end

   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         o_working          <= W_RESET;
         o_status           <= STATUS_RESET;
         o_indirect_pointer <= POINTER_RESET;
      end else if (phase == PH_FOUR && o_exec_valid) begin
         if (write_w) begin
            o_working <= res_q;
         end
         o_status <= next_status;
         if (write_file && eff_addr == ADDR_POINTER) begin
            o_indirect_pointer <= res_q;
         end
      end
   end

   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         seen_fetch <= 1'b0;
      end else if (phase == PH_FOUR) begin
         seen_fetch <= 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_rst);

   property p_phase_rotate;
      phase == PH_ONE |=> phase == PH_TWO ##1 phase == PH_THREE ##1 phase == PH_FOUR
                          ##1 phase == PH_ONE;
   endproperty
   a_phase_rotate : assert property (p_phase_rotate) else $error("phase order broken");

   property p_phase_onehot;
      $onehot({o_phase_one, o_phase_two, o_phase_three, o_phase_four});
   endproperty
   a_phase_onehot : assert property (p_phase_onehot) else $error("phases overlap");

   property p_fetch_addr;
      phase == PH_ONE |=> o_prog_addr == $past(fetch_wrap) ##1 $stable(o_prog_addr) [*3];
   endproperty
   a_fetch_addr : assert property (p_fetch_addr) else $error("fetch address wrong");

   property p_wrap;
      o_prog_addr < PROG_WORDS;
   endproperty
   a_wrap : assert property (p_wrap) else $error("fetch outside code space");

   property p_rd_phase;
      o_dmem_rd |-> phase == PH_TWO && !$past(o_dmem_rd);
   endproperty
   a_rd_phase : assert property (p_rd_phase) else $error("data read off phase two");

   property p_wr_phase;
      o_dmem_wr |-> phase == PH_FOUR && o_dmem_wdata == res_q;
   endproperty
   a_wr_phase : assert property (p_wr_phase) else $error("data write off phase four");

   property p_flush;
      phase == PH_FOUR && flush_now |=> !o_exec_valid [*4] ##1 o_exec_valid;
   endproperty
   a_flush : assert property (p_flush) else $error("prefetch not discarded");

   property p_first_fetch;
      o_exec_valid |-> seen_fetch;
   endproperty
   a_first_fetch : assert property (p_first_fetch) else $error("executed before fetch");

   property p_flag_keep;
      phase == PH_FOUR && o_exec_valid && write_file && eff_addr == ADDR_STATUS
         |=> ((o_status[2:0] ^ $past(flags_q)) & $past(mask_q)) == 3'h0;
   endproperty
   a_flag_keep : assert property (p_flag_keep) else $error("status flags overwritten");

   c_branch : cover property (phase == PH_FOUR && flush_now);
   c_write  : cover property (o_dmem_wr);
   c_status : cover property (phase == PH_FOUR && o_exec_valid && write_file &&
                              eff_addr == ADDR_STATUS && mask_q != 3'h0);
endmodule : quad_phase_fetch_execute_core

/* File: tb/mem_model.sv */
// program and data memory arrays on the far side of the core
module mem_model import core_pkg::*; #(
   parameter int PROG_DELAY = 1
) (
   input  wire logic        i_core_clk,
   input  wire logic [10:0] i_prog_addr,
   input  wire logic [7:0]  i_dmem_addr,
   input  wire logic        i_dmem_rd,
   input  wire logic        i_dmem_wr,
   input  wire logic [7:0]  i_dmem_wdata,
   output logic      [11:0] o_prog_data,
   output logic      [7:0]  o_dmem_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [11:0] prog [0:2047];
   logic [7:0]  data [0:255];
   logic [7:0]  last_rd = 8'h00;
   logic [10:0] seen_addr = 11'h000;
   logic [1:0]  age = 2'h0;
   // ---------------------------------------------------------------
   // program bus
   // ---------------------------------------------------------------
   // a slow array: the word shows garbage until it has settled
   always @(posedge i_core_clk) begin
      seen_addr <= i_prog_addr;
      age <= (seen_addr != i_prog_addr) ? 2'h0 : ((age == 2'h3) ? age : age + 2'h1);
   end
   assign o_prog_data = (seen_addr == i_prog_addr && int'(age) >= PROG_DELAY - 1) ?
                        prog[i_prog_addr] : ~prog[i_prog_addr];
   // ---------------------------------------------------------------
   // data bus
   // ---------------------------------------------------------------
   // when not read the bus is released, so it shows the inverse of the last byte
   assign o_dmem_rdata = i_dmem_rd ? data[i_dmem_addr] : ~last_rd;
   always @(posedge i_core_clk) begin
      if (i_dmem_rd) begin
         last_rd <= data[i_dmem_addr];
      end
      if (i_dmem_wr) begin
         data[i_dmem_addr] <= i_dmem_wdata;
      end
   end
endmodule : mem_model

/* File: tb/testbench.sv */
// self-checking bench for the quad phase fetch/execute core
module testbench import core_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic        i_core_clk = 1'b0;
   logic        i_rst      = 1'b1;
   logic [11:0] prog_data;
   logic [7:0]  dmem_rdata;
   logic [10:0] o_prog_addr;
   logic        o_phase_one, o_phase_two, o_phase_three, o_phase_four;
   logic [7:0]  o_dmem_addr;
   logic        o_dmem_rd, o_dmem_wr;
   logic [7:0]  o_dmem_wdata, o_working, o_status, o_indirect_pointer;
   logic        o_exec_valid;
   logic [3:0]  ph;
   logic [3:0]  prev_ph = 4'h0;
   logic [10:0] prev_pa = 11'h000;
   int          err_total = 0;
   int          n_checks = 0;
   // arithmetic, a branch, pointer use and a skip, then the wrap at 010h
   logic [11:0] code [0:15] = '{12'hC03, 12'h071, 12'h010, 12'h023, 12'h808, 12'hCFF,
                                12'hA00, 12'hA00, 12'hC5A, 12'hFFF, 12'h292, 12'h364,
                                12'h140, 12'h703, 12'hCFF, 12'hA00};
   assign ph = {o_phase_four, o_phase_three, o_phase_two, o_phase_one};
   always #2.5 i_core_clk = ~i_core_clk;

   quad_phase_fetch_execute_core #(.PROG_WORDS(11'h010)) quad_phase_fetch_execute_core_inst (
      .i_core_clk(i_core_clk), .i_rst(i_rst), .i_prog_data(prog_data),
      .i_dmem_rdata(dmem_rdata), .o_prog_addr(o_prog_addr), .o_phase_one(o_phase_one),
      .o_phase_two(o_phase_two), .o_phase_three(o_phase_three),
      .o_phase_four(o_phase_four), .o_dmem_addr(o_dmem_addr), .o_dmem_rd(o_dmem_rd),
      .o_dmem_wr(o_dmem_wr), .o_dmem_wdata(o_dmem_wdata), .o_working(o_working),
      .o_status(o_status), .o_indirect_pointer(o_indirect_pointer),
      .o_exec_valid(o_exec_valid));
   mem_model #(.PROG_DELAY(2)) mem_model_inst (
      .i_core_clk(i_core_clk), .i_prog_addr(o_prog_addr), .i_dmem_addr(o_dmem_addr),
      .i_dmem_rd(o_dmem_rd), .i_dmem_wr(o_dmem_wr), .i_dmem_wdata(o_dmem_wdata),
      .o_prog_data(prog_data), .o_dmem_rdata(dmem_rdata));

   // ---------------------------------------------------------------
   // shared helpers
   // ---------------------------------------------------------------
   task automatic check(input string what, input logic [11:0] exp, input logic [11:0] got);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   // ends at the phase one after the next instruction cycle, its writes landed
   task automatic step();
      do @(negedge i_core_clk); while (o_phase_four !== 1'b1);
      @(negedge i_core_clk);
   endtask : step

   task automatic conclude();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : conclude

   // ---------------------------------------------------------------
   // cycle monitor: phases, fetch moment, data strobes
   // ---------------------------------------------------------------
   always @(negedge i_core_clk) begin
      if (!i_rst && prev_ph !== 4'h0) begin
         check("phase", {8'h00, prev_ph[2:0], prev_ph[3]}, {8'h00, ph});
         if (prev_pa !== o_prog_addr) begin
            check("fetch moment", 12'h001, {11'h000, prev_ph[0]});
         end
         if (o_dmem_rd) begin
            check("read phase", 12'h002, {8'h00, ph});
         end
         if (o_dmem_wr) begin
            check("write phase", 12'h008, {8'h00, ph});
         end
         if (o_dmem_rd || o_dmem_wr) begin
            check("inner address out", 12'h000,
                  {11'h000, (o_dmem_addr inside {8'h00, 8'h02, 8'h03, 8'h04})});
         end
      end
      prev_ph <= ph;
      prev_pa <= o_prog_addr;
   end

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic test_reset();
      check("reset address", 12'h000, {1'b0, o_prog_addr});
      check("reset status", 12'h018, {4'h0, o_status});
      check("reset phase", 12'h001, {8'h00, ph});
      check("reset valid", 12'h000, {11'h000, o_exec_valid});
      step();
      check("first valid", 12'h001, {11'h000, o_exec_valid});
      check("first address", 12'h000, {1'b0, o_prog_addr});
      check("nothing run", 12'h000, {4'h0, o_working});
      $display("test reset done");
   endtask : test_reset

   task automatic test_alu();
      step();
      check("literal move", 12'h003, {4'h0, o_working});
      step();
      check("sub to file", 12'h0FE, {4'h0, mem_model_inst.data[8'h11]});
      check("sub borrow", 12'h018, {4'h0, o_status});
      check("w kept", 12'h003, {4'h0, o_working});
      step();
      check("add wrap", 12'h000, {4'h0, o_working});
      check("add flags", 12'h01F, {4'h0, o_status});
      step();
      check("status dest", 12'h018, {4'h0, o_status});
      $display("test alu done");
   endtask : test_alu

   task automatic test_branch();
      step();
      check("flushed slot", 12'h000, {11'h000, o_exec_valid});
      step();
      check("discarded word", 12'h000, {4'h0, o_working});
      check("target fetched", 12'h008, {1'b0, o_prog_addr});
      check("target valid", 12'h001, {11'h000, o_exec_valid});
      step();
      check("target run", 12'h05A, {4'h0, o_working});
      step();
      check("xor literal", 12'h0A5, {4'h0, o_working});
      step();
      check("rotate right", 12'h040, {4'h0, o_working});
      check("rotate carry", 12'h019, {4'h0, o_status});
      $display("test branch done");
   endtask : test_branch

   task automatic test_indirect();
      step();
      check("pointer write", 12'h040, {4'h0, o_indirect_pointer});
      step();
      check("indirect read", 12'h05C, {4'h0, o_working});
      step();
      check("skipped slot", 12'h000, {11'h000, o_exec_valid});
      step();
      check("skip discards", 12'h05C, {4'h0, o_working});
      check("after skip", 12'h001, {11'h000, o_exec_valid});
      $display("test indirect done");
   endtask : test_indirect

   task automatic test_wrap();
      int n;
      n = 0;
      while (o_prog_addr !== 11'h00F && n < 80) begin
         @(negedge i_core_clk);
         n++;
      end
      while (o_prog_addr === 11'h00F && n < 80) begin
         @(negedge i_core_clk);
         n++;
      end
      check("wrap address", 12'h000, {1'b0, o_prog_addr});
      $display("test wrap done");
   endtask : test_wrap

   // ---------------------------------------------------------------
   // main sequence and watchdog
   // ---------------------------------------------------------------
   initial begin
      for (int i = 0; i < 2048; i++) begin
         mem_model_inst.prog[i] = (i < 16) ? code[i] : 12'hA00;
      end
      for (int i = 0; i < 256; i++) begin
         mem_model_inst.data[i] = 8'h00;
      end
      mem_model_inst.data[8'h10] = 8'hFD;
      mem_model_inst.data[8'h11] = 8'h01;
      mem_model_inst.data[8'h12] = 8'h81;
      mem_model_inst.data[8'h40] = 8'h5C;
      repeat (3) @(negedge i_core_clk);
      i_rst <= 1'b0;
      test_reset();
      test_alu();
      test_branch();
      test_indirect();
      test_wrap();
      conclude();
   end

   // whole run needs under a hundred cycles
   initial begin
      repeat (2000) @(posedge i_core_clk);
      err_total++;
      $display("ERROR watchdog expected done seen hang");
      conclude();
   end
endmodule : testbench
